// *** rtl/ramp_seq_map.svh ***
`ifndef RAMP_SEQ_MAP_SVH
`define RAMP_SEQ_MAP_SVH
// register offsets
`define RAMP_RATE_OFFSET     8'h03
`define OFF_DELAY_OFFSET     8'h06
`define CUR_LIMIT_OFFSET     8'h08
`define THRESH_OFFSET        8'h01
// reset values
`define OFF_DELAY_RESET      6'h0B
`define RISE_RESET           3'h1
`define RISE_RESET_TERM      3'h0
`define FALL_RESET           3'h1
`define FALL_RESET_TERM      3'h0
`define CUR_LIMIT_RESET      4'hB
`define CUR_LIMIT_MAX        4'hB
`define RISE_RESERVED        3'h7
// field positions
`define FALL_EN_BIT          3
`define RISE_LSB             4
// reference step in units of 2.5 mV codes (10 mV)
`define STEP_CODES           12'h004
// master clock ticks per millisecond
`define TICKS_PER_MS         16'd50000
`endif

// *** rtl/ramp_seq_pkg.sv ***
package ramp_seq_pkg;
    // sequencer states
    typedef enum logic [4:0] {
        ST_OFF     = 5'b00001,
        ST_RISE    = 5'b00010,
        ST_ON      = 5'b00100,
        ST_WAIT    = 5'b01000,
        ST_FALL    = 5'b10000
    } seq_state_e;
    typedef logic [11:0] vcode_t;
endpackage

// *** rtl/step_timer.sv ***
`timescale 1ns/100ps
`include "ramp_seq_map.svh"
// divides the master clock into ramp step ticks
module step_timer (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // control
    input  wire logic        run,
    input  wire logic [15:0] step_len,
    // tick out
    output logic             tick
);
    logic [15:0] count;      // ticks elapsed in step
    // reload at step end, count while running
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else if (count + 16'h0001 >= step_len) begin
            count <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule

// *** rtl/output_ramp_sequencer.sv ***
`timescale 1ns/100ps
`include "ramp_seq_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - off delay ends when output reaches zero
// - wait equals delay minus ramp-down time
// - no ramp: delay just times switch-off
// - six-bit off delay ms, reset eleven
// - reference moves in fixed 10 mV steps
// - step time divided from master clock
// - rising rate codes zero to six
// - bit three enables falling ramp
// - falling rate codes select ramp-down rate
// - pre-bias holds switching until reference crosses
// - limits scale as percent of setpoint
// - current limit codes above 0xB clamp
// - fall rate independent, shorter delay range
//////////////////////////////////////////////////////////////////////////////
module output_ramp_sequencer
    import ramp_seq_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        bus_terminator,
    // register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // commands and levels
    input  wire logic        turn_on_cmd,
    input  wire logic        turn_off_cmd,
    input  wire logic [11:0] setpoint,
    input  wire logic [11:0] prebias_level,
    input  wire logic [7:0]  ov_pct,
    input  wire logic [7:0]  uv_pct,
    // outputs
    output logic      [11:0] vref,
    output logic             switching_en,
    output logic      [19:0] ov_limit,
    output logic      [19:0] uv_limit,
    output logic      [3:0]  current_limit_code,
    output logic             ramping
);
    //////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [5:0]  off_delay_ms;     // off delay in ms
    logic [2:0]  rise_code;        // rising rate
    logic        fall_ramp_enable; // falling ramp control
    logic [2:0]  fall_code;        // falling rate
    logic [7:0]  current_limit_reg;// regulation and limit
    seq_state_e  state;
    logic [23:0] wait_cyc;         // cycles left in pre-ramp wait or plain delay
    logic        tick;

    // rate code to cycles per 10 mV step (50 MHz)
    function automatic logic [15:0] step_cycles(input logic [2:0] code);
        case (code)
            3'h0:    step_cycles = 16'd10000; // 0.05 V/ms
            3'h1:    step_cycles = 16'd5000;  // 0.1
            3'h2:    step_cycles = 16'd2500;  // 0.2
            3'h3:    step_cycles = 16'd2000;  // 0.25
            3'h4:    step_cycles = 16'd1000;  // 0.5
            3'h5:    step_cycles = 16'd500;   // 1.0
            default: step_cycles = 16'd250;   // 2.0
        endcase
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // decode
    wire wr_ramp  = reg_wr && reg_addr == `RAMP_RATE_OFFSET;
    wire wr_off   = reg_wr && reg_addr == `OFF_DELAY_OFFSET;
    wire wr_cur   = reg_wr && reg_addr == `CUR_LIMIT_OFFSET;
    wire [2:0] wr_rise = reg_wdata[6:4];
    // ramp-down time in cycles: 10 mV steps from present reference times step length
    wire [10:0] fall_steps = 11'(({1'b0, vref} + 13'h0003) >> 2);
    wire [23:0] ramp_cyc   = {13'h0000, fall_steps} * {8'h00, step_cycles(fall_code)};
    // whole off delay in cycles; the ramp is carved out of it, not added to it
    wire [23:0] delay_cyc  = {18'h00000, off_delay_ms} * {8'h00, `TICKS_PER_MS};
    // pre-ramp wait, clamped at zero when the ramp outlasts the delay
    wire [23:0] next_wait  = (delay_cyc > ramp_cyc) ?
                             delay_cyc - ramp_cyc : 24'h000000;
    // 13-bit compare so a step near full scale cannot wrap
    wire [11:0] vref_up    = ({1'b0, vref} + 13'h0004 > {1'b0, setpoint}) ?
                             setpoint : vref + `STEP_CODES;
    wire [11:0] vref_dn    = (vref < `STEP_CODES) ? 12'h000 : vref - `STEP_CODES;
    wire        run_timer = state == ST_RISE || state == ST_FALL;
    wire [15:0] step_len  = step_cycles(state == ST_FALL ? fall_code : rise_code);

    // step tick from divided master clock
    step_timer u_step (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .run      (run_timer),
        .step_len (step_len),
        .tick     (tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            off_delay_ms      <= `OFF_DELAY_RESET;
            rise_code         <= bus_terminator ? `RISE_RESET_TERM : `RISE_RESET;
            fall_code         <= `FALL_RESET;
            fall_ramp_enable  <= 1'b1;
            current_limit_reg <= {4'h0, `CUR_LIMIT_RESET};
        end else begin
            if (wr_off)
                off_delay_ms <= reg_wdata[5:0];
            if (wr_ramp) begin
                if (wr_rise != `RISE_RESERVED)
                    rise_code <= wr_rise;
                fall_ramp_enable <= reg_wdata[`FALL_EN_BIT];
                fall_code        <= reg_wdata[2:0];
            end
            if (wr_cur)
                current_limit_reg <= reg_wdata;
        end
    end

    // readback, unused bits zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            case (reg_addr)
                `RAMP_RATE_OFFSET: reg_rdata <= {1'b0, rise_code, fall_ramp_enable, fall_code};
                `OFF_DELAY_OFFSET: reg_rdata <= {2'b00, off_delay_ms};
                `CUR_LIMIT_OFFSET: reg_rdata <= current_limit_reg;
                default:           reg_rdata <= 8'h00;
            endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state        <= ST_OFF;
            vref         <= 12'h000;
            switching_en <= 1'b0;
            wait_cyc     <= 24'h000000;
            ramping      <= 1'b0;
        end else begin
            case (state)
                ST_OFF: begin
                    vref <= 12'h000;
                    if (turn_on_cmd) begin
                        state   <= ST_RISE;
                        ramping <= 1'b1;
                    end
                end
                ST_RISE: begin
                    if (tick)
                        vref <= vref_up;
                    if (vref >= prebias_level)
                        switching_en <= 1'b1;
                    if (turn_off_cmd) begin
                        state   <= ST_WAIT;
                        ramping <= 1'b0;
                        wait_cyc <= fall_ramp_enable ? next_wait : delay_cyc;
                    end else if (vref == setpoint) begin
                        state   <= ST_ON;
                        ramping <= 1'b0;
                    end
                end
                ST_ON: begin
                    vref <= setpoint;                             // follows margining
                    if (turn_off_cmd) begin
                        state   <= ST_WAIT;
                        wait_cyc <= fall_ramp_enable ? next_wait : delay_cyc;
                    end
                end
                ST_WAIT: begin
                    if (wait_cyc == 24'h000000) begin
                        if (fall_ramp_enable) begin
                            state   <= ST_FALL;
                            ramping <= 1'b1;
                        end else begin
                            state        <= ST_OFF;
                            switching_en <= 1'b0;
                        end
                    end else
                        wait_cyc <= wait_cyc - 24'h000001;
                end
                ST_FALL: begin
                    if (tick)
                        vref <= vref_dn;
                    if (vref == 12'h000) begin
                        state        <= ST_OFF;
                        switching_en <= 1'b0;
                        ramping      <= 1'b0;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // thresholds as percent of setpoint, current-limit clamp
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ov_limit           <= 20'h00000;
            uv_limit           <= 20'h00000;
            current_limit_code <= `CUR_LIMIT_RESET;
        end else begin
            ov_limit <= setpoint * ov_pct;
            uv_limit <= setpoint * uv_pct;
            current_limit_code <= (current_limit_reg[3:0] > `CUR_LIMIT_MAX) ?
                                  `CUR_LIMIT_MAX : current_limit_reg[3:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    reserved_rise_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ramp && wr_rise == `RISE_RESERVED) |=> $stable(rise_code))
        else $error("reserved rise code changed rate");
    cur_clamp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        current_limit_code <= `CUR_LIMIT_MAX)
        else $error("current limit above max");
    fall_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_FALL && tick && vref >= `STEP_CODES) |=> vref == $past(vref) - `STEP_CODES)
        else $error("fall step not 10 mV");
    no_ramp_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_WAIT && wait_cyc == 24'h000000 && !fall_ramp_enable) |=> !switching_en)
        else $error("switches not off after delay");
    wait_to_fall_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_WAIT && wait_cyc == 24'h000000 && fall_ramp_enable) |=> state == ST_FALL)
        else $error("ramp-down not started");
    prebias_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_RISE && $rose(switching_en)) |-> $past(vref) >= $past(prebias_level))
        else $error("switching before pre-bias crossed");
    off_default_a: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> off_delay_ms == `OFF_DELAY_RESET && fall_ramp_enable)
        else $error("bad reset defaults");
    rise_default_a: assert property (@(posedge ref_clk)
        $fell(sys_rst) |-> rise_code == ($past(bus_terminator) ? `RISE_RESET_TERM : `RISE_RESET))
        else $error("bad rising rate default");
    fall_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_FALL && vref == 12'h000) |=> state == ST_OFF && !switching_en)
        else $error("fall did not end at zero");
endmodule

// *** verification/power_manager_model.sv ***
`timescale 1ns/100ps
// manager stand-in: register writes, reads and on/off commands
module power_manager_model (
    // clock
    input  wire logic       ref_clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // commands
    output logic            turn_on_cmd,
    output logic            turn_off_cmd
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        turn_on_cmd = 1'b0;
        turn_off_cmd = 1'b0;
    end
    // one write; released data turns to its inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // one read, data taken once it has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1 d = reg_rdata;
    endtask
    // limit nibble by read-modify-write, regulation bits kept
    task automatic set_limit(input logic [3:0] code);
        logic [7:0] v;
        rd(8'h08, v);
        wr(8'h08, {v[7:4], code});
    endtask
    // one-cycle command pulse
    task automatic pulse(input logic off);
        @(posedge ref_clk);
        turn_on_cmd <= ~off;
        turn_off_cmd <= off;
        @(posedge ref_clk);
        turn_on_cmd <= 1'b0;
        turn_off_cmd <= 1'b0;
    endtask
endmodule

// *** verification/output_ramp_sequencer_tb.sv ***
`timescale 1ns/100ps
// bench for the ramp sequencer
module output_ramp_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reg_wr, reg_rd, turn_on_cmd, turn_off_cmd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
    logic [11:0] setpoint = 12'h000;
    logic [11:0] prebias_level = 12'h000;
    logic [7:0]  ov_pct = 8'h6E;
    logic [7:0]  uv_pct = 8'h5A;
    logic        bus_terminator = 1'b0;
    logic [11:0] vref;
    logic [19:0] ov_limit, uv_limit;
    logic [3:0]  current_limit_code;
    logic        switching_en, ramping;
    int          n_fail = 0;
    int          compares = 0;
    int          n;
    output_ramp_sequencer output_ramp_sequencer_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .bus_terminator(bus_terminator), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .turn_on_cmd(turn_on_cmd),
        .turn_off_cmd(turn_off_cmd), .setpoint(setpoint), .prebias_level(prebias_level),
        .ov_pct(ov_pct), .uv_pct(uv_pct), .vref(vref), .switching_en(switching_en),
        .ov_limit(ov_limit), .uv_limit(uv_limit),
        .current_limit_code(current_limit_code), .ramping(ramping));
    power_manager_model power_manager_model_i (.ref_clk(ref_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .turn_on_cmd(turn_on_cmd), .turn_off_cmd(turn_off_cmd));
    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // cycles until: 0 ramping, 1 reference at zero, 2 switching stopped
    task automatic measure(input int sel, output int c);
        c = 0;
        while (!(sel == 0 ? ramping === 1'b1 : sel == 1 ? vref === 12'h000 :
                 switching_en === 1'b0) && c < 70000) begin
            @(posedge ref_clk);
            c++;
        end
    endtask
    // reset values, clamps, reserved code
    task automatic t_regs;
        power_manager_model_i.rd(8'h06, rv);
        check("off_rst", rv, 8'h0B);
        power_manager_model_i.rd(8'h03, rv);
        check("ramp_rst", rv, 8'h19);
        power_manager_model_i.rd(8'h20, rv);
        check("unmapped", rv, 8'h00);
        check("lim_rst", current_limit_code, 4'hB);
        power_manager_model_i.wr(8'h06, 8'hFF);
        power_manager_model_i.rd(8'h06, rv);
        check("off_bits", rv, 8'h3F);
        power_manager_model_i.wr(8'h03, 8'h7A);
        power_manager_model_i.rd(8'h03, rv);
        check("rise_rsvd", rv, 8'h1A);
        power_manager_model_i.wr(8'h08, 8'h5B);
        power_manager_model_i.set_limit(4'h3);
        repeat (2) @(posedge ref_clk);
        check("lim_3", current_limit_code, 4'h3);
        power_manager_model_i.rd(8'h08, rv);
        check("reg_bits", rv, 8'h53);
        power_manager_model_i.set_limit(4'hF);
        repeat (2) @(posedge ref_clk);
        check("lim_clamp", current_limit_code, 4'hB);
    endtask
    // mid-run reset in bus terminator mode: slowest rising default
    task automatic t_term;
        sys_rst <= 1'b1;
        bus_terminator <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        power_manager_model_i.rd(8'h03, rv);
        check("term_rst", rv, 8'h09);
        check("term_lim", current_limit_code, 4'hB);
    endtask
    // rise at 2.0 V/ms into 50 mV pre-bias, 100 mV target
    task automatic t_rise;
        setpoint <= 12'h028;
        prebias_level <= 12'h014;
        power_manager_model_i.wr(8'h03, 8'h6B);
        power_manager_model_i.pulse(1'b0);
        measure(0, n);
        @(vref);
        #1 check("step_size", vref, 12'h004);
        check("prebias_hold", switching_en, 1'b0);
        n = 0;
        while (vref === 12'h004 && n < 1000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check("step_time", n, 250);
        repeat (2100) @(posedge ref_clk);
        check("rise_end", vref, 12'h028);
        check("sw_on", switching_en, 1'b1);
        check("ov_lim", ov_limit, 20'd4400);
        check("uv_lim", uv_limit, 20'd3600);
        // margining: limits follow a new setpoint and new percentages
        setpoint <= 12'h030;
        ov_pct <= 8'h78;
        uv_pct <= 8'h5F;
        repeat (2) @(posedge ref_clk);
        check("ov_move", ov_limit, 20'd5760);
        check("uv_move", uv_limit, 20'd4560);
        setpoint <= 12'h028;
    endtask
    // 1 ms off delay, 0.4 ms ramp at -0.25 V/ms, wait stays positive
    task automatic t_fall;
        power_manager_model_i.wr(8'h06, 8'h01);
        power_manager_model_i.pulse(1'b1);
        measure(0, n);
        check("pre_wait", n >= 29994 && n <= 30004, 1'b1);
        measure(1, n);
        check("fall_time", n >= 19996 && n <= 20004, 1'b1);
        repeat (3) @(posedge ref_clk);
        check("sw_off", switching_en, 1'b0);
    endtask
    // no ramp: delay only times switch-off
    task automatic t_noramp;
        power_manager_model_i.pulse(1'b0);
        repeat (2600) @(posedge ref_clk);
        power_manager_model_i.wr(8'h03, 8'h63);
        power_manager_model_i.pulse(1'b1);
        measure(2, n);
        check("off_only", n >= 49994 && n <= 50004, 1'b1);
        check("no_ramp", ramping, 1'b0);
    endtask
    // zero delay with ramp: ramp-down at once
    task automatic t_zero;
        power_manager_model_i.pulse(1'b0);
        repeat (2600) @(posedge ref_clk);
        power_manager_model_i.wr(8'h03, 8'h6B);
        power_manager_model_i.wr(8'h06, 8'h00);
        power_manager_model_i.pulse(1'b1);
        measure(0, n);
        check("zero_wait", n <= 3, 1'b1);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_term;
        t_rise;
        t_fall;
        t_noramp;
        t_zero;
        complete_run;
    end
    // watchdog
    initial begin
        #2400000;
        n_fail++;
        complete_run;
    end
endmodule
